// File: logic/pmfs_pkg.sv
// pmfs_pkg: command codes, field positions, masks and carriers for the fault status bank.
// assumes the PMBus front end decodes transactions into single command-code accesses.
package pmfs_pkg;

  // command codes of the bank
  localparam logic [7:0] CMD_FAULT_SUMMARY_WORD = 8'h79;
  localparam logic [7:0] CMD_OUTPUT_VOLTAGE_FLAGS = 8'h7A;
  localparam logic [7:0] CMD_OUTPUT_CURRENT_FLAGS = 8'h7B;
  localparam logic [7:0] CMD_INPUT_FLAGS = 8'h7C;
  localparam logic [7:0] CMD_TEMPERATURE_FLAGS = 8'h7D;

  // special summary-word writes
  localparam logic [15:0] SUM_CLR_BUSY = 16'h0080;
  localparam logic [15:0] SUM_CLR_BUSY_UNKNOWN = 16'h0180;

  // summary word bit positions
  localparam int SUM_VOUT_BIT = 15;
  localparam int SUM_IOUT_BIT = 14;
  localparam int SUM_INPUT_BIT = 13;
  localparam int SUM_MFR_BIT = 12;
  localparam int SUM_PGOOD_BIT = 11;
  localparam int SUM_OTHER_BIT = 9;
  localparam int SUM_UNKNOWN_BIT = 8;
  localparam int SUM_BUSY_BIT = 7;
  localparam int SUM_OFF_BIT = 6;
  localparam int SUM_VOUT_OV_BIT = 5;
  localparam int SUM_IOUT_OC_BIT = 4;
  localparam int SUM_VIN_UV_BIT = 3;
  localparam int SUM_TEMP_BIT = 2;
  localparam int SUM_CML_BIT = 1;

  // detail field positions used by the summary
  localparam int VOUT_OV_FAULT_BIT = 7;
  localparam int IOUT_OC_FAULT_BIT = 7;
  localparam int VIN_UV_FAULT_BIT = 4;

  // supported bits of each detail register
  localparam logic [7:0] VOUT_MASK = 8'hFC;
  localparam logic [7:0] IOUT_MASK = 8'hB8;
  localparam logic [7:0] INPUT_MASK = 8'hFF;
  localparam logic [7:0] TEMP_MASK = 8'hC0;

  // values after reset
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [15:0] RDATA_RESET = 16'h0000;

  // input_flags layout, for reference by the event source
  localparam int INPUT_OV_FAULT_BIT = 7;
  localparam int INPUT_LOW_VIN_BIT = 3;
  localparam int INPUT_OC_FAULT_BIT = 2;
  localparam int INPUT_OC_WARN_BIT = 1;
  localparam int INPUT_OVERPOWER_WARNING_BIT = 0;

  // one-cycle event pulses from the regulator and the bus front end
  typedef struct packed {
    logic [7:0] vout;
    logic [7:0] iout;
    logic [7:0] input_ev;
    logic [7:0] temp;
    logic busy;
    logic unknown;
  } pmfs_evt_s;

  // register access request from the bus front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] cmd;
    logic [15:0] wdata;
  } pmfs_req_s;

endpackage

// File: logic/pmfs_status_bank.sv
// pmfs_status_bank: latched fault/warning flags and the summary word, read and cleared by command code.
// assumes event pulses and requests come from logic on CLK_I; power-good and enable are pins.
//
// Operation
// [R1] summary bit 15 is set while any output-voltage flag is latched
// [R2] summary bit 14 is set while any output-current flag is latched
// [R3] summary bit 13 is set while any input flag is latched
// [R4] summary bit 12 reflects any manufacturer-specific fault or warning
// [R5] summary bit 11 reads 1 while power-good is low
// [R6] summary bit 9 reflects any other fault
// [R7] summary bit 7 latches when a busy fault is declared
// [R8] summary bit 6 set while output is off for lack of enable, not fault
// [R9] summary bits 5, 4, 3: output OV, output OC, input UV faults
// [R10] summary bit 2 temperature, bit 1 communication/memory/logic fault
// [R11] writing 0080h to the summary word clears only busy
// [R12] writing 0180h to the summary word clears busy and unknown
// [R13] output-voltage flags latch in bits 7 to 2
// [R14] detail flags clear on clear-faults or on writing 1; 0 keeps them
// [R15] output-current flags latch in bits 7, 5, 4 and 3
// [R16] input flags latch OV fault, OV warn, UV warn, UV fault in 7..4
// [R17] input bit 3 latches on shutdown for insufficient input voltage
// [R18] input bits 2, 1, 0: input OC fault, OC warning, overpower warning
// [R19] temperature flags latch fault in bit 7 and warning in bit 6
// [R20] summary bits follow detail flags; clearing a flag clears its summary bit
// [R21] each category summary bit is the OR of its latched flags; bits 12, 9 and 1 copy unlatched input levels
`timescale 1ns/1ps
module pmfs_status_bank
  import pmfs_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire pmfs_evt_s EVT_I,
  input wire logic MFR_FAULT_I,
  input wire logic CML_FAULT_I,
  input wire logic OTHER_FAULT_I,
  input wire logic CLEAR_FAULTS_I,
  input wire logic PGOOD_I,
  input wire logic ENABLED_I,
  input wire pmfs_req_s REQ_I,
  output logic [15:0] RDATA_O,
  output logic RVALID_O,
  output logic CMD_ERR_O,
  output logic [15:0] SUMMARY_O
);

  // latched flags; set beats clear so an event in the clearing cycle survives
  function automatic logic [7:0] latch_flags(input logic [7:0] cur, input logic [7:0] set,
                                             input logic [7:0] w1c, input logic clr_all,
                                             input logic [7:0] mask);
    logic [7:0] kept;
    kept = clr_all ? 8'h00 : (cur & ~w1c);
    latch_flags = (kept | set) & mask;
  endfunction

  // command decode, shared by the write side and the read side
  function automatic logic cmd_mapped(input logic [7:0] cmd);
    logic hit;
    hit = 1'b0;
    unique case (cmd)
      CMD_FAULT_SUMMARY_WORD: begin
        hit = 1'b1;
      end
      CMD_OUTPUT_VOLTAGE_FLAGS: begin
        hit = 1'b1;
      end
      CMD_OUTPUT_CURRENT_FLAGS: begin
        hit = 1'b1;
      end
      CMD_INPUT_FLAGS: begin
        hit = 1'b1;
      end
      CMD_TEMPERATURE_FLAGS: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    cmd_mapped = hit;
  endfunction

  // [R14] write-one-to-clear bits aimed at one byte register
  function automatic logic [7:0] w1c_bits(input pmfs_req_s req, input logic [7:0] cmd);
    logic [7:0] bits;
    bits = 8'h00;
    if (req.wr && (req.cmd == cmd)) begin
      bits = req.wdata[7:0];
    end
    w1c_bits = bits;
  endfunction

  logic [7:0] vout_q;
  logic [7:0] iout_q;
  logic [7:0] input_q;
  logic [7:0] temp_q;
  logic busy_q;
  logic unknown_q;
  logic pgood_meta_q;
  logic pgood_q;
  logic enabled_meta_q;
  logic enabled_q;
  logic [15:0] rdata_q;
  logic rvalid_q;
  logic cmd_err_q;
  logic [15:0] summary_d;
  logic [15:0] rdata_d;
  logic hit_d;
  logic wr_sum;
  logic clr_busy;
  logic clr_unknown;
  logic [7:0] w1c_vout;
  logic [7:0] w1c_iout;
  logic [7:0] w1c_input;
  logic [7:0] w1c_temp;

  // write decode; only supported bits are ever affected
  assign wr_sum = REQ_I.wr && (REQ_I.cmd == CMD_FAULT_SUMMARY_WORD);
  assign w1c_vout = w1c_bits(REQ_I, CMD_OUTPUT_VOLTAGE_FLAGS);
  assign w1c_iout = w1c_bits(REQ_I, CMD_OUTPUT_CURRENT_FLAGS);
  assign w1c_input = w1c_bits(REQ_I, CMD_INPUT_FLAGS);
  assign w1c_temp = w1c_bits(REQ_I, CMD_TEMPERATURE_FLAGS);
  assign hit_d = cmd_mapped(REQ_I.cmd);

  // [R11] [R12] special summary values; any other summary write is dropped
  assign clr_busy = CLEAR_FAULTS_I ||
                    (wr_sum && (REQ_I.wdata == SUM_CLR_BUSY || REQ_I.wdata == SUM_CLR_BUSY_UNKNOWN));
  assign clr_unknown = CLEAR_FAULTS_I || (wr_sum && REQ_I.wdata == SUM_CLR_BUSY_UNKNOWN);

  // power-good pin; reads as not good until two edges after reset
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pgood_meta_q <= 1'b0;
      pgood_q <= 1'b0;
    end else begin
      pgood_meta_q <= PGOOD_I;
      pgood_q <= pgood_meta_q;
    end
  end

  // enable pin; reads as off until two edges after reset
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      enabled_meta_q <= 1'b0;
      enabled_q <= 1'b0;
    end else begin
      enabled_meta_q <= ENABLED_I;
      enabled_q <= enabled_meta_q;
    end
  end

  // [R13] [R14] output-voltage flags
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      vout_q <= FLAGS_RESET;
    end else begin
      vout_q <= latch_flags(vout_q, EVT_I.vout, w1c_vout, CLEAR_FAULTS_I, VOUT_MASK);
    end
  end

  // [R15] [R14] output-current flags
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      iout_q <= FLAGS_RESET;
    end else begin
      iout_q <= latch_flags(iout_q, EVT_I.iout, w1c_iout, CLEAR_FAULTS_I, IOUT_MASK);
    end
  end

  // [R16] [R17] [R18] [R14] input flags, all eight bits supported
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      input_q <= FLAGS_RESET;
    end else begin
      input_q <= latch_flags(input_q, EVT_I.input_ev, w1c_input, CLEAR_FAULTS_I, INPUT_MASK);
    end
  end

  // [R19] [R14] temperature flags
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      temp_q <= FLAGS_RESET;
    end else begin
      temp_q <= latch_flags(temp_q, EVT_I.temp, w1c_temp, CLEAR_FAULTS_I, TEMP_MASK);
    end
  end

  // [R7] [R11] busy latch, cleared by either special value or clear-faults
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      busy_q <= 1'b0;
    end else if (EVT_I.busy) begin
      busy_q <= 1'b1;
    end else if (clr_busy) begin
      busy_q <= 1'b0;
    end
  end

  // [R12] unknown latch; other summary writes are ignored
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      unknown_q <= 1'b0;
    end else if (EVT_I.unknown) begin
      unknown_q <= 1'b1;
    end else if (clr_unknown) begin
      unknown_q <= 1'b0;
    end
  end

  // summary is derived only, so it cannot disagree with the detail flags
  always_comb begin
    summary_d = 16'h0000;
    // [R1] [R21] output voltage category
    summary_d[SUM_VOUT_BIT] = |vout_q;
    // [R2] [R21] output current category
    summary_d[SUM_IOUT_BIT] = |iout_q;
    // [R3] [R21] input category
    summary_d[SUM_INPUT_BIT] = |input_q;
    // [R4] manufacturer category
    summary_d[SUM_MFR_BIT] = MFR_FAULT_I;
    // [R5] power-good negated
    summary_d[SUM_PGOOD_BIT] = ~pgood_q;
    // [R6] other category
    summary_d[SUM_OTHER_BIT] = OTHER_FAULT_I;
    summary_d[SUM_UNKNOWN_BIT] = unknown_q;
    // [R7] busy fault
    summary_d[SUM_BUSY_BIT] = busy_q;
    // [R8] off only for lack of enable, never for a fault shutdown
    summary_d[SUM_OFF_BIT] = ~enabled_q;
    // [R9] [R20] single faults mirrored from their detail flags
    summary_d[SUM_VOUT_OV_BIT] = vout_q[VOUT_OV_FAULT_BIT];
    summary_d[SUM_IOUT_OC_BIT] = iout_q[IOUT_OC_FAULT_BIT];
    summary_d[SUM_VIN_UV_BIT] = input_q[VIN_UV_FAULT_BIT];
    // [R10] [R21] temperature and communication
    summary_d[SUM_TEMP_BIT] = |temp_q;
    summary_d[SUM_CML_BIT] = CML_FAULT_I;
  end

  // read mux; byte registers sit in the low bits
  always_comb begin
    rdata_d = 16'h0000;
    unique case (REQ_I.cmd)
      CMD_FAULT_SUMMARY_WORD: begin
        rdata_d = summary_d;
      end
      CMD_OUTPUT_VOLTAGE_FLAGS: begin
        rdata_d = {8'h00, vout_q};
      end
      CMD_OUTPUT_CURRENT_FLAGS: begin
        rdata_d = {8'h00, iout_q};
      end
      CMD_INPUT_FLAGS: begin
        rdata_d = {8'h00, input_q};
      end
      CMD_TEMPERATURE_FLAGS: begin
        rdata_d = {8'h00, temp_q};
      end
      default: begin
        rdata_d = 16'h0000;
      end
    endcase
  end

  // answer one cycle after the request; reads see flags before this cycle's updates
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= REQ_I.rd;
    end
  end

  // unmapped access flagged for one cycle, reads and writes alike
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      cmd_err_q <= 1'b0;
    end else begin
      cmd_err_q <= (REQ_I.rd || REQ_I.wr) && !hit_d;
    end
  end

  // read data holds until the next read so a slow host can still fetch it
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rdata_q <= RDATA_RESET;
    end else if (REQ_I.rd) begin
      rdata_q <= hit_d ? rdata_d : RDATA_RESET;
    end
  end

  assign RDATA_O = rdata_q;
  assign RVALID_O = rvalid_q;
  assign CMD_ERR_O = cmd_err_q;
  assign SUMMARY_O = summary_d;

endmodule

// File: testbench/pmfs_status_bank_assertions.sv
// pmfs_status_bank_assertions: port-level checks of the fault status bank.
// assumes bound to pmfs_status_bank, one clock, async active-low reset.
`timescale 1ns/1ps
module pmfs_status_bank_assertions
  import pmfs_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire pmfs_evt_s EVT_I,
  input wire logic MFR_FAULT_I,
  input wire logic CML_FAULT_I,
  input wire logic OTHER_FAULT_I,
  input wire logic CLEAR_FAULTS_I,
  input wire logic PGOOD_I,
  input wire logic ENABLED_I,
  input wire pmfs_req_s REQ_I,
  input wire logic [15:0] RDATA_O,
  input wire logic RVALID_O,
  input wire logic CMD_ERR_O,
  input wire logic [15:0] SUMMARY_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  wire logic mapped = REQ_I.cmd >= CMD_FAULT_SUMMARY_WORD && REQ_I.cmd <= CMD_TEMPERATURE_FLAGS;
  wire logic quiet = !EVT_I.busy && !EVT_I.unknown && !CLEAR_FAULTS_I;
  wire logic sum_wr = REQ_I.wr && REQ_I.cmd == CMD_FAULT_SUMMARY_WORD;
  AST_VOUT_OV: assert property (EVT_I.vout[7] |=> SUMMARY_O[15] && SUMMARY_O[5])
    else $error("output overvoltage missing from summary");
  AST_IOUT_OC: assert property (EVT_I.iout[7] |=> SUMMARY_O[14] && SUMMARY_O[4])
    else $error("output overcurrent missing from summary");
  AST_VIN_UV: assert property (EVT_I.input_ev[4] |=> SUMMARY_O[13] && SUMMARY_O[3])
    else $error("input undervoltage missing from summary");
  AST_LEVELS: assert property (SUMMARY_O[12] == MFR_FAULT_I && SUMMARY_O[9] == OTHER_FAULT_I)
    else $error("level categories wrong in summary");
  AST_PGOOD: assert property ($stable(PGOOD_I) [*3] ##0 $past(RESETN_I, 2) |-> SUMMARY_O[11] == !PGOOD_I)
    else $error("power-good bit wrong");
  AST_OFF: assert property ($stable(ENABLED_I) [*3] ##0 $past(RESETN_I, 2) |-> SUMMARY_O[6] == !ENABLED_I)
    else $error("off bit wrong");
  AST_BUSY_SET: assert property (EVT_I.busy |=> SUMMARY_O[7])
    else $error("busy fault not flagged");
  AST_BUSY_CLR: assert property (sum_wr && REQ_I.wdata == SUM_CLR_BUSY && quiet |=>
    !SUMMARY_O[7] && $stable(SUMMARY_O[8])) else $error("busy clear wrong");
  AST_UNKNOWN_CLR: assert property (sum_wr && REQ_I.wdata == SUM_CLR_BUSY_UNKNOWN && quiet |=>
    !SUMMARY_O[7] && !SUMMARY_O[8]) else $error("busy and unknown clear wrong");
  AST_CLEAR: assert property (CLEAR_FAULTS_I && EVT_I == '0 |=> (SUMMARY_O & 16'hE1BC) == 16'h0000)
    else $error("clear-faults left flags");
  AST_UNMAPPED: assert property (REQ_I.rd && !mapped |=> CMD_ERR_O && RDATA_O == 16'h0000)
    else $error("unmapped read not refused");
  AST_RVALID: assert property (REQ_I.rd && mapped |=> RVALID_O && !CMD_ERR_O)
    else $error("read answer missing");
endmodule

// File: testbench/pmfs_host_model.sv
// pmfs_host_model: host issuing single register reads and writes.
// assumes the bank takes a request at one edge and answers at the next.
`timescale 1ns/1ps
module pmfs_host_model
  import pmfs_pkg::*;
(
  input wire logic clk_i,
  input wire logic [15:0] rdata_i,
  output pmfs_req_s req_o
);
  initial req_o = '0;
  task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
    @(negedge clk_i);
    req_o = '{wr: 1'b1, rd: 1'b0, cmd: cmd, wdata: data};
    @(negedge clk_i);
    // released fields show garbage, not the last value
    req_o = '{wr: 1'b0, rd: 1'b0, cmd: ~cmd, wdata: ~data};
  endtask
  task automatic rd(input logic [7:0] cmd, output logic [15:0] data);
    @(negedge clk_i);
    req_o = '{wr: 1'b0, rd: 1'b1, cmd: cmd, wdata: 16'h5A5A};
    @(negedge clk_i);
    data = rdata_i;
    req_o = '{wr: 1'b0, rd: 1'b0, cmd: ~cmd, wdata: 16'hA5A5};
  endtask
endmodule

// File: testbench/pmfs_status_bank_test.sv
// pmfs_status_bank_test: register-level tests of the fault status bank.
// assumes the host model drives requests; events and pins driven here.
`timescale 1ns/1ps
module pmfs_status_bank_test import pmfs_pkg::*;;
  logic clk, rst_n, mfr, cml, oth, clr, pgood, en, rvalid, cmd_err;
  logic [15:0] rdata, summary;
  pmfs_evt_s evt;
  pmfs_req_s req;
  int n_fail = 0;
  int num_checks = 0;
  localparam logic [7:0] CMDS [4] = '{8'h7A, 8'h7B, 8'h7C, 8'h7D};
  localparam logic [7:0] MASKS [4] = '{8'hFC, 8'hB8, 8'hFF, 8'hC0};
  localparam logic [15:0] SUMS [4] = '{16'h8020, 16'h4010, 16'h2008, 16'h0004};
  pmfs_status_bank u_pmfs_status_bank (.CLK_I(clk), .RESETN_I(rst_n), .EVT_I(evt), .MFR_FAULT_I(mfr),
    .CML_FAULT_I(cml), .OTHER_FAULT_I(oth), .CLEAR_FAULTS_I(clr), .PGOOD_I(pgood), .ENABLED_I(en),
    .REQ_I(req), .RDATA_O(rdata), .RVALID_O(rvalid), .CMD_ERR_O(cmd_err), .SUMMARY_O(summary));
  pmfs_host_model u_host (.clk_i(clk), .rdata_i(rdata), .req_o(req));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] cmd, input logic [15:0] exp);
    logic [15:0] d;
    u_host.rd(cmd, d);
    chk(d, exp);
  endtask
  task automatic fire(input pmfs_evt_s e, input logic c);
    @(negedge clk);
    evt = e;
    clr = c;
    @(negedge clk);
    evt = '0;
    clr = 1'b0;
  endtask
  task automatic end_of_test();
    if (n_fail == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #20000;
    n_fail++;
    end_of_test();
  end
  initial begin
    {rst_n, mfr, cml, oth, clr, pgood, en} = 7'b0000011;
    evt = '0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    rdchk(CMD_FAULT_SUMMARY_WORD, 16'h0000);
    {mfr, cml, oth, pgood, en} = 5'b11100;
    repeat (3) @(negedge clk);
    rdchk(CMD_FAULT_SUMMARY_WORD, 16'h1A42);
    {mfr, cml, oth, pgood, en} = 5'b00011;
    repeat (3) @(negedge clk);
    for (int i = 0; i < 4; i++) begin
      fire(pmfs_evt_s'({8'hFF, 26'h0} >> (8 * i)), 1'b0);
      rdchk(CMDS[i], {8'h00, MASKS[i]});
      rdchk(CMD_FAULT_SUMMARY_WORD, SUMS[i]);
      u_host.wr(CMDS[i], 16'h0000);
      rdchk(CMDS[i], {8'h00, MASKS[i]});
      u_host.wr(CMDS[i], 16'h00FF);
      rdchk(CMDS[i], 16'h0000);
      rdchk(CMD_FAULT_SUMMARY_WORD, 16'h0000);
    end
    // two input flags, undervoltage warning and fault; clear only the undervoltage fault
    fire(pmfs_evt_s'(34'h0_0000_C000), 1'b0);
    u_host.wr(CMD_INPUT_FLAGS, 16'h0010);
    rdchk(CMD_FAULT_SUMMARY_WORD, 16'h2000);
    fire(pmfs_evt_s'(34'h3), 1'b0);
    rdchk(CMD_FAULT_SUMMARY_WORD, 16'h2180);
    u_host.wr(CMD_FAULT_SUMMARY_WORD, 16'h0080);
    rdchk(CMD_FAULT_SUMMARY_WORD, 16'h2100);
    u_host.wr(CMD_FAULT_SUMMARY_WORD, 16'h0100);
    rdchk(CMD_FAULT_SUMMARY_WORD, 16'h2100);
    u_host.wr(CMD_FAULT_SUMMARY_WORD, 16'h0180);
    rdchk(CMD_FAULT_SUMMARY_WORD, 16'h2000);
    fire(pmfs_evt_s'(34'h3_FFFF_FFFF), 1'b0);
    fire('0, 1'b1);
    rdchk(CMD_FAULT_SUMMARY_WORD, 16'h0000);
    rdchk(CMD_INPUT_FLAGS, 16'h0000);
    // mid-run reset with every flag latched
    fire(pmfs_evt_s'(34'h3_FFFF_FFFF), 1'b0);
    @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    rdchk(CMD_FAULT_SUMMARY_WORD, 16'h0000);
    rdchk(CMD_OUTPUT_VOLTAGE_FLAGS, 16'h0000);
    rdchk(8'h7E, 16'h0000);
    chk({15'h0000, cmd_err}, 16'h0001);
    end_of_test();
  end
endmodule
bind pmfs_status_bank pmfs_status_bank_assertions u_chk (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .EVT_I(EVT_I),
  .MFR_FAULT_I(MFR_FAULT_I), .CML_FAULT_I(CML_FAULT_I), .OTHER_FAULT_I(OTHER_FAULT_I),
  .CLEAR_FAULTS_I(CLEAR_FAULTS_I), .PGOOD_I(PGOOD_I), .ENABLED_I(ENABLED_I), .REQ_I(REQ_I),
  .RDATA_O(RDATA_O), .RVALID_O(RVALID_O), .CMD_ERR_O(CMD_ERR_O), .SUMMARY_O(SUMMARY_O));
